// [rtl/sipo_cfg.svh]
`ifndef SIPO_CFG_SVH
`define SIPO_CFG_SVH

// ****************************************
// widths, depths and reset values
// ****************************************
`define STAGE_COUNT 8
`define STAGE_RESET 8'h00
`define BUF_DEPTH 2
`define BUF_COUNT_W 2
`define BUF_FULL_COUNT 2'h2

`endif

// [rtl/sipo_pkg.sv]
`include "sipo_cfg.svh"

package sipo_pkg;

  // ****************************************
  // shared types
  // ****************************************
  typedef logic [`STAGE_COUNT-1:0] stage_word_t;

  // gray codes along run -> wait -> clear
  typedef enum logic [1:0]
  {
    ST_RUN = 2'h0,
    ST_WAIT = 2'h1,
    ST_CLEAR = 2'h3
  } ctl_state_t;

endpackage

// [rtl/word_buf_if.sv]
`timescale 1ns/1ps

interface word_buf_if;
  import sipo_pkg::*;

  // ****************************************
  // fill side and drain side
  // ****************************************
  logic push_valid;
  logic push_ready;
  stage_word_t push_data;
  logic pop_valid;
  logic pop_ready;
  stage_word_t pop_data;

  modport filler
  (
    output push_valid,
    output push_data,
    input push_ready
  );

  modport store
  (
    input push_valid,
    input push_data,
    output push_ready,
    output pop_valid,
    output pop_data,
    input pop_ready
  );

  modport drainer
  (
    input pop_valid,
    input pop_data,
    output pop_ready
  );
endinterface

// [rtl/word_buf.sv]
`timescale 1ns/1ps
`include "sipo_cfg.svh"

module word_buf
  import sipo_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  word_buf_if.store bus
);

  // ****************************************
  // two-entry store
  // ****************************************
  stage_word_t mem_r [0:`BUF_DEPTH-1];
  stage_word_t mem_nxt [0:`BUF_DEPTH-1];
  logic wr_ptr_r;
  logic wr_ptr_nxt;
  logic rd_ptr_r;
  logic rd_ptr_nxt;
  logic [`BUF_COUNT_W-1:0] count_r;
  logic [`BUF_COUNT_W-1:0] count_nxt;
  logic do_push;
  logic do_pop;

  // pointer step shared by both ends
  function automatic logic ptr_step(input logic ptr, input logic go);
    ptr_step = go ? ~ptr : ptr;
  endfunction

  // honest flags straight from the count
  assign bus.push_ready = (count_r != `BUF_FULL_COUNT);
  assign bus.pop_valid = (count_r != 2'h0);
  assign bus.pop_data = mem_r[rd_ptr_r];
  assign do_push = bus.push_valid && bus.push_ready;
  assign do_pop = bus.pop_valid && bus.pop_ready;

  // next pointers, count and contents
  always_comb
  begin
    mem_nxt = mem_r;
    if (do_push)
    begin
      mem_nxt[wr_ptr_r] = bus.push_data;
    end
    wr_ptr_nxt = ptr_step(wr_ptr_r, do_push);
    rd_ptr_nxt = ptr_step(rd_ptr_r, do_pop);
    count_nxt = count_r;
    if (do_push && !do_pop)
    begin
      count_nxt = count_r + 2'h1;
    end
    else if (do_pop && !do_push)
    begin
      count_nxt = count_r - 2'h1;
    end
  end

  // register only
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      mem_r[0] <= `STAGE_RESET;
      mem_r[1] <= `STAGE_RESET;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      mem_r <= mem_nxt;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  buf_never_over_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    count_r <= `BUF_FULL_COUNT)
    else $error("buffer count above depth");

  buf_word_out_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (do_push && count_r == 2'h0) |=> (bus.pop_valid && bus.pop_data == $past(bus.push_data)))
    else $error("word pushed into empty buffer not presented next cycle");

  buf_stall_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (bus.pop_valid && !bus.pop_ready) |=> (bus.pop_valid && $stable(bus.pop_data)))
    else $error("stalled word changed or vanished");

endmodule

// [rtl/gated_sipo.sv]
`timescale 1ns/1ps
`include "sipo_cfg.svh"

module gated_sipo
  import sipo_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_b_in,
  input wire logic shift_clock_in,
  input wire logic ser_a_in,
  input wire logic ser_b_in,
  input wire logic clear_n_in,
  output logic [`STAGE_COUNT-1:0] stage_outputs_out,
  output logic shift_ready_out,
  output logic word_valid_out,
  output logic [`STAGE_COUNT-1:0] word_data_out,
  input wire logic word_ready_in
);

  // ****************************************
  // state
  // ****************************************
  stage_word_t stage_r;
  stage_word_t stage_nxt;
  ctl_state_t state_r;
  ctl_state_t state_nxt;
  logic clk_prev_r;
  logic clk_prev_nxt;
  logic pend_bit_r;
  logic pend_bit_nxt;
  logic clk_rise;
  logic entry_bit;
  logic room;
  logic shift_fire;
  logic load_bit;

  word_buf_if buf_bus ();

  // pins are synchronous, so a plain previous-value compare finds the edge
  assign clk_rise = shift_clock_in && !clk_prev_r;

  assign entry_bit = ser_a_in & ser_b_in;

  // a full buffer defers the edge rather than losing a snapshot
  assign room = buf_bus.push_ready;
  assign shift_ready_out = room;

  // clear outranks clock
  // an edge in the cycle that clear is released is taken as well, so the clear
  // state behaves like run here; only a waiting edge replays without a new one
  assign shift_fire = clear_n_in && room &&
                      ((state_r != ST_WAIT && clk_rise) || state_r == ST_WAIT);

  assign load_bit = (state_r == ST_WAIT) ? pend_bit_r : entry_bit;

  // ****************************************
  // control sequence
  // ****************************************
  // deferred edges keep their captured bit; clear drops them
  always_comb
  begin
    state_nxt = state_r;
    pend_bit_nxt = pend_bit_r;
    clk_prev_nxt = shift_clock_in;
    case (state_r)
      ST_RUN:
      begin
        if (!clear_n_in)
        begin
          state_nxt = ST_CLEAR;
        end
        else if (clk_rise && !room)
        begin
          state_nxt = ST_WAIT;
          pend_bit_nxt = entry_bit;
        end
      end
      ST_WAIT:
      begin
        // edges that arrive now are refused; the first one keeps its slot
        if (!clear_n_in)
        begin
          state_nxt = ST_CLEAR;
        end
        else if (room)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_CLEAR:
      begin
        // an edge in the release cycle is a normal edge and may need deferring too
        if (clear_n_in && clk_rise && !room)
        begin
          state_nxt = ST_WAIT;
          pend_bit_nxt = entry_bit;
        end
        else if (clear_n_in)
        begin
          state_nxt = ST_RUN;
        end
      end
      default:
      begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // stage chain
  // ****************************************
  always_comb
  begin
    stage_nxt = stage_r;
    if (!clear_n_in)
    begin
      stage_nxt = `STAGE_RESET;
    end
    else if (shift_fire)
    begin
      stage_nxt = {stage_r[`STAGE_COUNT-2:0], load_bit};
    end
  end

  // each fired shift hands its snapshot to the buffer
  assign buf_bus.push_valid = shift_fire;
  assign buf_bus.push_data = stage_nxt;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      stage_r <= `STAGE_RESET;
      state_r <= ST_RUN;
      clk_prev_r <= 1'b0;
      pend_bit_r <= 1'b0;
    end
    else
    begin
      stage_r <= stage_nxt;
      state_r <= state_nxt;
      clk_prev_r <= clk_prev_nxt;
      pend_bit_r <= pend_bit_nxt;
    end
  end

  // parallel outputs forced low at once by clear
  assign stage_outputs_out = clear_n_in ? stage_r : `STAGE_RESET;

  // ****************************************
  // output buffer
  // ****************************************
  // clear does not empty the buffer: words already taken stay for the receiver,
  // only the system reset throws them away
  word_buf u_word_buf
  (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .bus(buf_bus.store)
  );

  assign word_valid_out = buf_bus.pop_valid;
  assign word_data_out = buf_bus.pop_data;
  assign buf_bus.pop_ready = word_ready_in;

  // ****************************************
  // checks
  // ****************************************
  shift_move_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    shift_fire |=> stage_r[`STAGE_COUNT-1:1] == $past(stage_r[`STAGE_COUNT-2:0]))
    else $error("stages did not move one place");

  stage_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (shift_fire && state_r == ST_RUN) |=> stage_r[0] == $past(ser_a_in && ser_b_in))
    else $error("stage zero not loaded with AND of inputs");

  gate_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (shift_fire && state_r == ST_RUN && !(ser_a_in && ser_b_in)) |=> !stage_r[0])
    else $error("gated input let a one through");

  clear_force_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    !clear_n_in |-> (stage_outputs_out == 8'h00) ##1 (stage_r == 8'h00))
    else $error("outputs not low during clear");

  clear_prio_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (!clear_n_in ##1 !clear_n_in) |-> (stage_r == 8'h00 && !buf_bus.push_valid))
    else $error("shift took place during clear");

  hold_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clear_n_in && !shift_fire) |=> $stable(stage_r))
    else $error("stages changed without an edge");

  outputs_show_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    clear_n_in |-> stage_outputs_out == stage_r)
    else $error("outputs differ from stages");

  edge_defer_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state_r == ST_RUN && clk_rise && !room && clear_n_in)
      |=> (state_r == ST_WAIT && pend_bit_r == $past(ser_a_in && ser_b_in)))
    else $error("stalled edge not held with its captured bit");

  single_step_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (clear_n_in && state_r == ST_RUN && !clk_rise) |=> $stable(stage_r))
    else $error("stages moved without a rising edge");

  release_edge_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state_r == ST_CLEAR && clear_n_in && clk_rise && room) |=> stage_r[0] == $past(ser_a_in && ser_b_in))
    else $error("edge in clear release cycle was lost");

  wait_resume_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state_r == ST_WAIT && room && clear_n_in) |=> (state_r == ST_RUN && stage_r[0] == $past(pend_bit_r)))
    else $error("deferred edge did not load its captured bit");

  wait_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in)
    (state_r == ST_WAIT && !room && clear_n_in)
      |=> (state_r == ST_WAIT && $stable(stage_r) && $stable(pend_bit_r)))
    else $error("waiting edge lost or stages moved while buffer full");

endmodule

// [sim/serial_driver.sv]
`timescale 1ns/1ps

// ****************************************
// far-side logic feeding the serial inputs
// ****************************************
module serial_driver
(
  input wire logic clk_sys_in,
  output logic shift_clock_out,
  output logic ser_a_out,
  output logic ser_b_out
);
  initial
  begin
    shift_clock_out = 1'b0;
    ser_a_out = 1'b1;
    ser_b_out = 1'b1;
  end

  // one rising shift clock edge carrying a and b
  task automatic pulse(input logic a, input logic b);
    @(negedge clk_sys_in);
    ser_a_out = a;
    ser_b_out = b;
    shift_clock_out = 1'b1;
    @(negedge clk_sys_in);
    shift_clock_out = 1'b0;
    // hold time over: stale data must not be captured later
    ser_a_out = ~a;
    ser_b_out = ~b;
  endtask
endmodule

// [sim/gated_serial_in_parallel_out_shift_reg_tb_top.sv]
`timescale 1ns/1ps

module gated_serial_in_parallel_out_shift_reg_tb_top;
  import sipo_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic clear_n_in = 1'b1;
  logic word_ready_in = 1'b0;
  logic shift_clock, ser_a, ser_b, shift_ready_out, word_valid_out;
  stage_word_t stage_outputs_out, word_data_out;
  int failures = 0;
  int checks = 0;
  int model = 0;
  int ready_mode = 0;
  int words[$];

  always #10 clk_sys_in = ~clk_sys_in;

  gated_sipo i_gated_sipo
  (
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .shift_clock_in(shift_clock),
    .ser_a_in(ser_a),
    .ser_b_in(ser_b),
    .clear_n_in(clear_n_in),
    .stage_outputs_out(stage_outputs_out),
    .shift_ready_out(shift_ready_out),
    .word_valid_out(word_valid_out),
    .word_data_out(word_data_out),
    .word_ready_in(word_ready_in)
  );

  serial_driver i_serial_driver
  (
    .clk_sys_in(clk_sys_in),
    .shift_clock_out(shift_clock),
    .ser_a_out(ser_a),
    .ser_b_out(ser_b)
  );

  // ****************************************
  // compare and report
  // ****************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // bounded wait for room in the word buffer
  task automatic wait_ready();
    int n;
    for (n = 0; n < 60 && shift_ready_out !== 1'b1; n++)
      @(negedge clk_sys_in);
    if (n == 60)
    begin
      failures++;
      finish_test();
    end
  endtask

  // bounded drain of the word buffer
  task automatic drain();
    int n;
    for (n = 0; n < 20 && word_valid_out !== 1'b0; n++)
      @(negedge clk_sys_in);
    if (n == 20)
    begin
      failures++;
      finish_test();
    end
  endtask

  // one bit through the model and the design
  task automatic shift_bit(input logic a, input logic b);
    wait_ready();
    i_serial_driver.pulse(a, b);
    model = ((model << 1) | int'(a & b)) & 8'hFF;
    words.push_back(model);
    check("stages", stage_outputs_out, model[7:0]);
  endtask

  // receiver: low, high or random readiness, changed off the sampling edge
  always @(negedge clk_sys_in)
    word_ready_in <= (ready_mode == 2) ? 1'($urandom % 2) : (ready_mode == 1);

  // words leave oldest first, one per shift
  always @(posedge clk_sys_in)
    if (rst_b_in && word_valid_out === 1'b1 && word_ready_in === 1'b1)
      check("word", word_data_out, (words.size() > 0) ? 8'(words.pop_front()) : 8'hXX);

  initial
  begin
    int i;
    void'($urandom(40));
    repeat (2) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    check("reset", {shift_ready_out, word_valid_out, stage_outputs_out[5:0]}, 8'h80);
    check("reset stages", stage_outputs_out, 8'h00);
    check("reset word", word_data_out, 8'h00);
    // every combination of the two gate inputs
    ready_mode = 1;
    for (i = 0; i < 4; i++)
      shift_bit(i[1], i[0]);
    // random bits against a stalling receiver
    ready_mode = 2;
    for (i = 0; i < 40; i++)
      shift_bit(1'($urandom), 1'($urandom));
    // drain, then fill until the buffer refuses
    ready_mode = 1;
    drain();
    ready_mode = 0;
    shift_bit(1'b1, 1'b1);
    shift_bit(1'b0, 1'b1);
    repeat (2) @(negedge clk_sys_in);
    check("full", 8'(shift_ready_out), 8'h00);
    // deferred edge: stages must hold while the buffer is full
    i_serial_driver.pulse(1'b1, 1'b1);
    repeat (3) @(negedge clk_sys_in);
    check("held", stage_outputs_out, model[7:0]);
    model = ((model << 1) | 1) & 8'hFF;
    words.push_back(model);
    ready_mode = 1;
    repeat (5) @(negedge clk_sys_in);
    check("deferred", stage_outputs_out, model[7:0]);
    // clear acts at once and blocks a shift edge
    clear_n_in = 1'b0;
    #1;
    check("clear", stage_outputs_out, 8'h00);
    i_serial_driver.pulse(1'b1, 1'b1);
    repeat (2) @(negedge clk_sys_in);
    // release with an edge in that same cycle: the edge counts, into a cleared chain
    fork
      i_serial_driver.pulse(1'b1, 1'b1);
      begin
        @(negedge clk_sys_in);
        clear_n_in = 1'b1;
      end
    join
    model = 1;
    words.push_back(model);
    check("clear hold", stage_outputs_out, 8'h01);
    shift_bit(1'b1, 1'b1);
    drain();
    check("drained", 8'(words.size()), 8'h00);
    finish_test();
  end
endmodule
